// ### src/rcpm_top.sv
// power and functional mode sequencer of the radio controller
`timescale 1ns/1ps
`default_nettype none
module rcpm_top #(
	parameter int RST_CYCLES = rcpm_pkg::RST_PIN_CYCLES
) (
	input  wire logic               mclk_i,        // system clock
	input  wire logic               rst_i,         // power-on reset
	input  wire logic               sel_pin_i,     // transport select pin
	input  wire logic               wake_or_chip_select_pin_i, // wake or cs
	input  wire logic               rst_pin_i,     // host reset pin
	input  wire logic               supply_ok_i,   // power check result
	input  wire logic               xtal_ready_i,  // crystal started
	input  wire logic               cmd_valid_i,   // decoded command pulse
	input  wire rcpm_pkg::rcpm_cmd_e cmd_code_i,   // command kind
	input  wire logic [1:0]         cmd_arg_i,     // command argument
	input  wire logic               radio_sleep_i, // firmware: radio idle
	input  wire logic               radio_wake_i,  // firmware: radio due
	input  wire logic               radio_stop_i,  // firmware: link ended
	input  wire logic               role_master_i, // link role is master
	output logic                    cmd_accept_o,  // command taken
	output logic                    cmd_reject_o,  // command refused
	output logic                    cmd_slow_o,    // reduced speed set
	output logic                    idle_event_o,  // idle entered pulse
	output logic                    event_spi_o,   // event via spi
	output logic                    rc_osc_en_o,   // rc oscillator on
	output logic                    xtal_en_o,     // crystal on
	output logic                    clk_xtal_o,    // logic on crystal
	output logic                    supply_low_o,  // logic supply lowered
	output logic                    radio_en_o,    // radio may run
	output logic                    rc_cal_o,      // rc calibration
	output logic                    rst_pad_o,     // reset pad out level
	output logic                    rst_pad_oe_o,  // reset pad drive
	output rcpm_pkg::rcpm_state_e   state_o        // functional state
);
	import rcpm_pkg::*;

	if (RST_CYCLES < 1 || RST_CYCLES >= (1 << RST_CNT_W)) begin : g_chk
		$error("RST_CYCLES out of counter range");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	rcpm_pin_if #(.W(PIN_W)) pins ();

	assign pins.raw = {xtal_ready_i, supply_ok_i, rst_pin_i,
		wake_or_chip_select_pin_i, sel_pin_i};

	rcpm_sync #(.W(PIN_W)) u_sync (
		.mclk_i (mclk_i),
		.rst_i  (rst_i),
		.pins   (pins)
	);

	logic spi_s;
	logic wake_s;
	logic rstp_s;
	logic supply_s;
	logic xtal_s;
	assign spi_s    = (pins.sync[PIN_SEL] == SEL_SPI);
	assign wake_s   = pins.sync[PIN_WAKE] && !spi_s;
	assign rstp_s   = pins.sync[PIN_RST];
	assign supply_s = pins.sync[PIN_SUPPLY];
	assign xtal_s   = pins.sync[PIN_XTAL];

	// ------------------------------------------------------------
	// state and registers
	// ------------------------------------------------------------
	rcpm_state_e          state_reg, state_next;
	logic [RST_CNT_W-1:0] rcnt_reg, rcnt_next;
	logic                 por_reg, por_next;
	logic                 rc_cfg_reg, rc_cfg_next;
	logic                 evt_reg, evt_next;
	logic                 evspi_reg, evspi_next;
	logic                 rc_osc_reg, rc_osc_next;
	logic                 xtal_reg, xtal_next;
	logic                 clkx_reg, clkx_next;
	logic                 low_reg, low_next;
	logic                 radio_reg, radio_next;
	logic                 cal_reg, cal_next;
	logic                 acc;
	logic                 rej;
	logic                 restricted;
	logic                 rc_sleep;

	// radio sleep on rc only when configured and not master
	assign rc_sleep = rc_cfg_reg && !role_master_i;

	always_comb begin
		state_next  = state_reg;
		rcnt_next   = rcnt_reg;
		por_next    = por_reg;
		rc_cfg_next = rc_cfg_reg;
		evt_next    = 1'b0;
		evspi_next  = evspi_reg;
		acc         = 1'b0;
		rej         = 1'b0;
		restricted  = 1'b0;
		case (state_reg)
		RCPM_POR_CHECK: begin
			// a crystal ready left over from before a reboot must clear
			if (supply_s && !xtal_s)
				state_next = RCPM_XTAL_START;
		end
		RCPM_XTAL_START, RCPM_WAKE: begin
			if (xtal_s) begin
				state_next = RCPM_IDLE;
				evt_next   = 1'b1;
				evspi_next = spi_s;
				por_next   = 1'b0;
			end
		end
		RCPM_IDLE: begin
			if (cmd_valid_i) begin
				acc = 1'b1;
				if (cmd_code_i == RCPM_CMD_RADIO_ON)
					state_next = RCPM_RADIO_ACTIVE;
				else if (cmd_code_i == RCPM_CMD_POWER_SET &&
						cmd_arg_i == RCPM_PM_SLEEP)
					state_next = RCPM_SLEEP;
				else if (cmd_code_i == RCPM_CMD_POWER_SET &&
						cmd_arg_i == RCPM_PM_OFF)
					state_next = RCPM_OFF;
			end
		end
		RCPM_SLEEP, RCPM_OFF: begin
			restricted = spi_s;
			if (!spi_s) begin
				rej = cmd_valid_i;
				if (wake_s)
					state_next = RCPM_WAKE;
			end else if (cmd_valid_i) begin
				// off wakes into sleep, then tries the command
				if (state_reg == RCPM_OFF)
					state_next = RCPM_SLEEP;
				if (cmd_code_i == RCPM_CMD_RADIO_ON) begin
					rej = 1'b1;
				end else begin
					acc = 1'b1;
					if (cmd_code_i == RCPM_CMD_POWER_SET &&
							cmd_arg_i == RCPM_PM_IDLE)
						state_next = RCPM_WAKE;
					else if (cmd_code_i == RCPM_CMD_POWER_SET &&
							cmd_arg_i == RCPM_PM_OFF)
						state_next = RCPM_OFF;
				end
			end
		end
		RCPM_RADIO_ACTIVE: begin
			acc = cmd_valid_i;
			if (radio_stop_i)
				state_next = RCPM_IDLE;
			else if (radio_sleep_i)
				state_next = RCPM_RADIO_SLEEP;
		end
		RCPM_RADIO_SLEEP: begin
			acc = cmd_valid_i;
			if (radio_stop_i)
				state_next = RCPM_IDLE;
			else if (radio_wake_i)
				state_next = RCPM_RADIO_ACTIVE;
		end
		default: state_next = RCPM_POR_CHECK;
		endcase
		// sleep clock config: rc only accepted under spi
		if (acc && cmd_code_i == RCPM_CMD_SLEEP_CFG) begin
			if (cmd_arg_i[CFG_RC_BIT] && !spi_s) begin
				acc = 1'b0;
				rej = 1'b1;
			end else begin
				rc_cfg_next = cmd_arg_i[CFG_RC_BIT];
			end
		end
		// reset pin held long enough reboots firmware
		if (!rstp_s) begin
			rcnt_next = '0;
		end else if (rcnt_reg == RST_CNT_W'(RST_CYCLES - 1)) begin
			rcnt_next   = '0;
			state_next  = RCPM_POR_CHECK;
			rc_cfg_next = 1'b0;
			evt_next    = 1'b0;
			evspi_next  = evspi_reg;
			por_next    = por_reg;
		end else begin
			rcnt_next = rcnt_reg + RST_CNT_W'(1);
		end
	end

	// oscillators and supply follow the next state
	always_comb begin
		rc_osc_next = 1'b1;
		xtal_next   = 1'b1;
		clkx_next   = 1'b1;
		low_next    = 1'b0;
		radio_next  = 1'b0;
		cal_next    = 1'b0;
		case (state_next)
		RCPM_POR_CHECK: begin
			xtal_next = 1'b0;
			clkx_next = 1'b0;
		end
		RCPM_XTAL_START, RCPM_WAKE: begin
			clkx_next = 1'b0;
		end
		RCPM_SLEEP: begin
			xtal_next = 1'b0;
			clkx_next = 1'b0;
			low_next  = 1'b1;
		end
		RCPM_OFF: begin
			rc_osc_next = 1'b0;
			xtal_next   = 1'b0;
			clkx_next   = 1'b0;
			low_next    = 1'b1;
		end
		RCPM_RADIO_ACTIVE: begin
			radio_next = 1'b1;
			cal_next   = 1'b1;
		end
		RCPM_RADIO_SLEEP: begin
			xtal_next = !rc_sleep;
			clkx_next = !rc_sleep;
			low_next  = rc_sleep;
		end
		default: begin
			rc_osc_next = 1'b1;
		end
		endcase
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			state_reg  <= RCPM_POR_CHECK;
			rcnt_reg   <= '0;
			por_reg    <= 1'b1;
			rc_cfg_reg <= 1'b0;
			evt_reg    <= 1'b0;
			evspi_reg  <= 1'b0;
			rc_osc_reg <= 1'b1;
			xtal_reg   <= 1'b0;
			clkx_reg   <= 1'b0;
			low_reg    <= 1'b0;
			radio_reg  <= 1'b0;
			cal_reg    <= 1'b0;
		end else begin
			state_reg  <= state_next;
			rcnt_reg   <= rcnt_next;
			por_reg    <= por_next;
			rc_cfg_reg <= rc_cfg_next;
			evt_reg    <= evt_next;
			evspi_reg  <= evspi_next;
			rc_osc_reg <= rc_osc_next;
			xtal_reg   <= xtal_next;
			clkx_reg   <= clkx_next;
			low_reg    <= low_next;
			radio_reg  <= radio_next;
			cal_reg    <= cal_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign cmd_accept_o = acc;
	assign cmd_reject_o = rej;
	assign cmd_slow_o   = restricted;
	assign idle_event_o = evt_reg;
	assign event_spi_o  = evspi_reg;
	assign rc_osc_en_o  = rc_osc_reg;
	assign xtal_en_o    = xtal_reg;
	assign clk_xtal_o   = clkx_reg;
	assign supply_low_o = low_reg;
	assign radio_en_o   = radio_reg;
	assign rc_cal_o     = cal_reg;
	assign rst_pad_o    = 1'b0;
	assign rst_pad_oe_o = por_reg;
	assign state_o      = state_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);

	power_check_a: assert property (
		state_reg == RCPM_POR_CHECK && supply_s && !rstp_s && !xtal_s
		|=> state_reg == RCPM_XTAL_START && xtal_en_o && !clk_xtal_o)
		else $error("crystal not started after power check");

	idle_event_a: assert property (
		state_reg == RCPM_XTAL_START && xtal_s && !rstp_s
		|=> state_reg == RCPM_IDLE && idle_event_o ##1 !idle_event_o)
		else $error("idle event missing after boot");

	standby_osc_a: assert property (
		state_reg == RCPM_IDLE
		|-> xtal_en_o && rc_osc_en_o && clk_xtal_o && !radio_en_o)
		else $error("idle not in standby");

	sleep_power_a: assert property (
		state_reg == RCPM_SLEEP
		|-> !xtal_en_o && rc_osc_en_o && supply_low_o && !radio_en_o)
		else $error("sleep not in retention mode");

	off_power_a: assert property (
		state_reg == RCPM_OFF |-> !xtal_en_o && !rc_osc_en_o && supply_low_o)
		else $error("off mode oscillators running");

	uart_sleep_a: assert property (
		(state_reg == RCPM_SLEEP || state_reg == RCPM_OFF) && !spi_s
		&& cmd_valid_i |-> cmd_reject_o && !cmd_accept_o)
		else $error("uart sleep accepted a command");

	radio_refuse_a: assert property (
		state_reg == RCPM_SLEEP && cmd_valid_i
		&& cmd_code_i == RCPM_CMD_RADIO_ON |-> cmd_reject_o
		##1 state_reg != RCPM_RADIO_ACTIVE)
		else $error("radio enabled from sleep");

	spi_off_wake_a: assert property (
		state_reg == RCPM_OFF && spi_s && cmd_valid_i && !rstp_s
		&& cmd_code_i == RCPM_CMD_OTHER |=> state_reg == RCPM_SLEEP)
		else $error("spi command did not wake off");

	radio_entry_a: assert property (
		$rose(state_reg == RCPM_RADIO_ACTIVE)
		|-> $past(state_reg) == RCPM_IDLE
		|| $past(state_reg) == RCPM_RADIO_SLEEP)
		else $error("radio active entered from wrong state");

	uart_rc_cfg_a: assert property (
		cmd_valid_i && cmd_code_i == RCPM_CMD_SLEEP_CFG
		&& cmd_arg_i[CFG_RC_BIT] && !spi_s |-> !cmd_accept_o)
		else $error("rc sleep clock accepted under uart");

	rst_pin_a: assert property (
		rstp_s && rcnt_reg == RST_CNT_W'(RST_CYCLES - 1)
		|=> state_reg == RCPM_POR_CHECK && rcnt_reg == '0)
		else $error("reset pin did not reboot");

	por_pad_a: assert property (
		$fell(rst_pad_oe_o) |-> $past(state_reg) == RCPM_XTAL_START
		&& idle_event_o)
		else $error("pad released before idle");
endmodule
`default_nettype wire

// ### src/rcpm_pkg.sv
// constants and types of the radio controller power mode sequencer
package rcpm_pkg;

	// timing
	localparam int MCLK_PERIOD_PS   = 8000;
	localparam int RST_PIN_MIN_MS   = 5;
	localparam int PS_PER_MS        = 1000000000;
	// divide first so the product stays inside a 32-bit int
	localparam int RST_PIN_CYCLES   =
		RST_PIN_MIN_MS * ((PS_PER_MS + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);
	localparam int RST_CNT_W        = 20;

	// synchronised pin positions
	localparam int PIN_W            = 5;
	localparam int PIN_SEL          = 0;
	localparam int PIN_WAKE         = 1;
	localparam int PIN_RST          = 2;
	localparam int PIN_SUPPLY       = 3;
	localparam int PIN_XTAL         = 4;

	// transport select level
	localparam logic SEL_SPI        = 1'b1;
	localparam logic SEL_UART       = 1'b0;

	// sleep clock config argument bit
	localparam int CFG_RC_BIT       = 0;

	typedef enum logic [7:0] {
		RCPM_POR_CHECK    = 8'h01,
		RCPM_XTAL_START   = 8'h02,
		RCPM_IDLE         = 8'h04,
		RCPM_SLEEP        = 8'h08,
		RCPM_OFF          = 8'h10,
		RCPM_RADIO_ACTIVE = 8'h20,
		RCPM_RADIO_SLEEP  = 8'h40,
		RCPM_WAKE         = 8'h80
	} rcpm_state_e;

	typedef enum logic [1:0] {
		RCPM_CMD_OTHER      = 2'h0,
		RCPM_CMD_POWER_SET  = 2'h1,
		RCPM_CMD_SLEEP_CFG  = 2'h2,
		RCPM_CMD_RADIO_ON   = 2'h3
	} rcpm_cmd_e;

	typedef enum logic [1:0] {
		RCPM_PM_IDLE  = 2'h0,
		RCPM_PM_SLEEP = 2'h1,
		RCPM_PM_OFF   = 2'h2
	} rcpm_pm_e;

endpackage

// ### src/rcpm_pin_if.sv
// raw and synchronised pin bundle between sequencer and synchroniser
`timescale 1ns/1ps
`default_nettype none
interface rcpm_pin_if #(parameter int W = 5);
	logic [W-1:0] raw;
	logic [W-1:0] sync;
	modport sync_side (input raw, output sync);
	modport user      (output raw, input sync);
endinterface
`default_nettype wire

// ### src/rcpm_sync.sv
// two flip-flop synchroniser for asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module rcpm_sync #(
	parameter int W = 5
) (
	input  wire logic   mclk_i, // system clock
	input  wire logic   rst_i,  // synchronous reset
	rcpm_pin_if.sync_side pins  // raw in, synced out
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] meta_next;
	logic [W-1:0] sync_reg;
	logic [W-1:0] sync_next;

	always_comb begin
		meta_next = pins.raw;
		sync_next = meta_reg;
	end

	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= meta_next;
			sync_reg <= sync_next;
		end
	end

	assign pins.sync = sync_reg;
endmodule
`default_nettype wire

// ### sim/rcpm_host_model.sv
// host side model: transport select, wake or chip select, reset pin, commands
`timescale 1ns/1ps
`default_nettype none
module rcpm_host_model (
	input  wire logic               mclk_i,     // system clock
	input  wire logic               accept_i,   // command taken
	input  wire logic               reject_i,   // command refused
	output var  logic               sel_pin_o,  // transport select
	output var  logic               wake_pin_o, // wake or chip select
	output var  logic               rst_pin_o,  // host reset pin
	output var  logic               valid_o,    // command pulse
	output var  rcpm_pkg::rcpm_cmd_e code_o,    // command kind
	output var  logic [1:0]         arg_o       // command argument
);
	import rcpm_pkg::*;
	initial begin
		sel_pin_o  = SEL_UART;
		wake_pin_o = 1'b0;
		rst_pin_o  = 1'b0;
		valid_o    = 1'b0;
		code_o     = RCPM_CMD_OTHER;
		arg_o      = 2'h0;
	end
	// select moves only while no exchange is running
	task automatic set_sel(input logic v);
		@(negedge mclk_i);
		sel_pin_o  = v;
		wake_pin_o = v;
		repeat (4) @(negedge mclk_i);
	endtask
	// wake level held past the synchroniser
	task automatic wake();
		@(negedge mclk_i);
		wake_pin_o = 1'b1;
		repeat (4) @(negedge mclk_i);
		wake_pin_o = 1'b0;
	endtask
	// one command, a spare cycle after each to keep traffic low
	task automatic send(input rcpm_cmd_e c, input logic [1:0] a,
		output logic acc, output logic rej);
		@(negedge mclk_i);
		if (sel_pin_o == SEL_SPI)
			wake_pin_o = 1'b0;
		valid_o = 1'b1;
		code_o  = c;
		arg_o   = a;
		@(posedge mclk_i);
		acc = accept_i;
		rej = reject_i;
		@(negedge mclk_i);
		valid_o    = 1'b0;
		arg_o      = ~a;
		wake_pin_o = sel_pin_o;
	endtask
	// reset pin high for n cycles; also the retry after a bad first event
	task automatic pin_reset(input int n);
		@(negedge mclk_i);
		rst_pin_o = 1'b1;
		repeat (n) @(negedge mclk_i);
		rst_pin_o = 1'b0;
	endtask
endmodule
`default_nettype wire

// ### sim/tb_rcpm_top.sv
// self-checking testbench of the power mode sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_rcpm_top;
	import rcpm_pkg::*;
	localparam int RC = 20;
	logic        mclk_i = 1'b0, rst_i = 1'b1, supply_ok = 1'b0;
	logic        xtal_ready = 1'b0, rs = 1'b0, rw = 1'b0, rstop = 1'b0;
	logic        master = 1'b0, sel, wake, rpin, cv;
	logic [1:0]  ca;
	rcpm_cmd_e   cc;
	logic        acc, rej, slow, ev, espi, rc_en, x_en, clk_x, s_low;
	logic        r_en, cal, pad, pad_oe;
	rcpm_state_e st;
	int          n_mismatch = 0, checks_done = 0, n_ev = 0, xcnt = 0;
	int          ev_base = 0;

	rcpm_top #(.RST_CYCLES(RC)) u_rcpm_top (.mclk_i(mclk_i), .rst_i(rst_i),
		.sel_pin_i(sel), .wake_or_chip_select_pin_i(wake),
		.rst_pin_i(rpin), .supply_ok_i(supply_ok),
		.xtal_ready_i(xtal_ready), .cmd_valid_i(cv), .cmd_code_i(cc),
		.cmd_arg_i(ca), .radio_sleep_i(rs), .radio_wake_i(rw),
		.radio_stop_i(rstop), .role_master_i(master),
		.cmd_accept_o(acc), .cmd_reject_o(rej), .cmd_slow_o(slow),
		.idle_event_o(ev), .event_spi_o(espi), .rc_osc_en_o(rc_en),
		.xtal_en_o(x_en), .clk_xtal_o(clk_x), .supply_low_o(s_low),
		.radio_en_o(r_en), .rc_cal_o(cal), .rst_pad_o(pad),
		.rst_pad_oe_o(pad_oe), .state_o(st));
	rcpm_host_model u_rcpm_host_model (.mclk_i(mclk_i), .accept_i(acc),
		.reject_i(rej), .sel_pin_o(sel), .wake_pin_o(wake),
		.rst_pin_o(rpin), .valid_o(cv), .code_o(cc), .arg_o(ca));

	initial forever #4 mclk_i = ~mclk_i;
	// crystal settles five cycles after enable, drops at once
	always @(negedge mclk_i) begin
		if (ev === 1'b1)
			n_ev++;
		if (x_en !== 1'b1) begin
			xcnt       <= 0;
			xtal_ready <= 1'b0;
		end else if (xcnt == 4)
			xtal_ready <= 1'b1;
		else
			xcnt <= xcnt + 1;
	end

	task automatic wrap_up();
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	function automatic logic [7:0] lv();
		return {2'h0, rc_en, x_en, clk_x, s_low, r_en, cal};
	endfunction
	// bounded wait, then one cycle so the event counter has landed
	task automatic wait_st(input rcpm_state_e s);
		for (int i = 0; i < 200 && st !== s; i++)
			@(negedge mclk_i);
		if (st !== s) begin
			check(st, s);
			wrap_up();
		end
		@(negedge mclk_i);
	endtask
	task automatic cmd(input rcpm_cmd_e c, input logic [1:0] a,
		input logic [1:0] exp);
		logic ac, rj;
		u_rcpm_host_model.send(c, a, ac, rj);
		check({6'h0, ac, rj}, {6'h0, exp});
	endtask
	task automatic fw(input logic [2:0] v);
		@(negedge mclk_i);
		{rs, rw, rstop} = v;
		@(negedge mclk_i);
		{rs, rw, rstop} = 3'h0;
	endtask

	task automatic t_boot();
		check(st, RCPM_POR_CHECK);
		check({6'h0, pad_oe, pad}, 8'h02);
		repeat (6) @(negedge mclk_i);
		check(lv(), 8'h20);
		supply_ok = 1'b1;
		wait_st(RCPM_XTAL_START);
		check(lv(), 8'h30);
		wait_st(RCPM_IDLE);
		check(lv(), 8'h38);
		check(8'(n_ev), 8'h01);
		check({7'h0, pad_oe}, 8'h00);
	endtask
	task automatic t_uart();
		cmd(RCPM_CMD_SLEEP_CFG, 2'h1, 2'h1);
		cmd(RCPM_CMD_SLEEP_CFG, 2'h0, 2'h2);
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_SLEEP, 2'h2);
		check(st, RCPM_SLEEP);
		check(lv(), 8'h24);
		cmd(RCPM_CMD_RADIO_ON, 2'h0, 2'h1);
		cmd(RCPM_CMD_OTHER, 2'h0, 2'h1);
		ev_base = n_ev;
		u_rcpm_host_model.wake();
		wait_st(RCPM_IDLE);
		check({7'h0, espi}, 8'h00);
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_OFF, 2'h2);
		check(lv(), 8'h04);
		cmd(RCPM_CMD_OTHER, 2'h0, 2'h1);
		u_rcpm_host_model.wake();
		wait_st(RCPM_IDLE);
		check(8'(n_ev - ev_base), 8'h02);
	endtask
	task automatic t_spi_sleep();
		u_rcpm_host_model.set_sel(SEL_SPI);
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_SLEEP, 2'h2);
		check({7'h0, slow}, 8'h01);
		cmd(RCPM_CMD_RADIO_ON, 2'h0, 2'h1);
		cmd(RCPM_CMD_OTHER, 2'h0, 2'h2);
		ev_base = n_ev;
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_IDLE, 2'h2);
		wait_st(RCPM_IDLE);
		check(8'(n_ev - ev_base), 8'h01);
		check({7'h0, espi}, 8'h01);
	endtask
	task automatic t_spi_off();
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_OFF, 2'h2);
		check(lv(), 8'h04);
		ev_base = n_ev;
		cmd(RCPM_CMD_OTHER, 2'h0, 2'h2);
		check(st, RCPM_SLEEP);
		cmd(RCPM_CMD_RADIO_ON, 2'h0, 2'h1);
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_OFF, 2'h2);
		check(st, RCPM_OFF);
		cmd(RCPM_CMD_OTHER, 2'h0, 2'h2);
		cmd(RCPM_CMD_POWER_SET, RCPM_PM_IDLE, 2'h2);
		wait_st(RCPM_IDLE);
		check(8'(n_ev - ev_base), 8'h01);
	endtask
	task automatic t_radio();
		cmd(RCPM_CMD_SLEEP_CFG, 2'h1, 2'h2);
		cmd(RCPM_CMD_RADIO_ON, 2'h0, 2'h2);
		check(lv(), 8'h3B);
		fw(3'h4);
		wait_st(RCPM_RADIO_SLEEP);
		check({5'h0, x_en, s_low, r_en}, 8'h02);
		cmd(RCPM_CMD_OTHER, 2'h0, 2'h2);
		fw(3'h2);
		wait_st(RCPM_RADIO_ACTIVE);
		master = 1'b1;
		fw(3'h4);
		wait_st(RCPM_RADIO_SLEEP);
		check({5'h0, x_en, s_low, r_en}, 8'h04);
		fw(3'h1);
		wait_st(RCPM_IDLE);
		master = 1'b0;
	endtask
	task automatic t_pin_reset();
		u_rcpm_host_model.pin_reset(RC - 4);
		repeat (4) @(negedge mclk_i);
		check(st, RCPM_IDLE);
		ev_base = n_ev;
		u_rcpm_host_model.pin_reset(RC + 4);
		// reboot must wait for a fresh crystal start
		wait_st(RCPM_XTAL_START);
		check(lv(), 8'h30);
		wait_st(RCPM_IDLE);
		check(8'(n_ev - ev_base), 8'h01);
		check({7'h0, pad_oe}, 8'h00);
		cmd(RCPM_CMD_RADIO_ON, 2'h0, 2'h2);
		fw(3'h4);
		wait_st(RCPM_RADIO_SLEEP);
		check({5'h0, x_en, s_low, r_en}, 8'h04);
	endtask

	initial begin
		repeat (10) @(negedge mclk_i);
		rst_i = 1'b0;
		t_boot();
		t_uart();
		t_spi_sleep();
		t_spi_off();
		t_radio();
		t_pin_reset();
		wrap_up();
	end
endmodule
`default_nettype wire
